// file: arm_stat_pkg.sv
// Constants, field layouts and carrier types of the arming and status registers.
// Assumes a register access port driven by the serial interface logic on core_clk_i.
package arm_stat_pkg;

  localparam logic [7:0] ADDR_POS_THR   = 8'h10;
  localparam logic [7:0] ADDR_NEG_THR   = 8'h12;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_TICK      = 8'h15;
  localparam logic [7:0] ADDR_DRIFT     = 8'h16;
  localparam logic [7:0] ADDR_RSVD_1C   = 8'h1c;
  localparam logic [7:0] ADDR_RSVD_1D   = 8'h1d;

  localparam logic [7:0] RST_THRESHOLD  = 8'h00;
  localparam logic [7:0] RST_TICK       = 8'h00;

  localparam int BIT_DATA_ERR = 6;
  localparam int BIT_MOD_OVR  = 5;
  localparam int BIT_INIT   = 4;
  localparam int BIT_MISO   = 3;
  localparam int BIT_DRIFT  = 1;
  localparam int BIT_RESET  = 0;

  localparam int PRESCALE_DIV  = 1024;
  localparam int PRESCALE_BITS = 10;

  localparam int          CRC_WIDTH = 3;
  localparam logic [2:0]  CRC_SEED  = 3'h7;
  localparam logic [2:0]  CRC_POLY  = 3'h3;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic mod_ovr;
    logic miso;
    logic drift;
  } fault_in_s;

  typedef enum logic [1:0] {
    CRC_IDLE,
    CRC_RUN,
    CRC_DONE
  } crc_state_e;

endpackage

// file: arm_stat_properties.sv
// Checker of the arming and status register bank.
// Assumes binding to arm_stat_regs, watching its ports only.
module arm_stat_properties
  import arm_stat_pkg::*;
#(
  parameter int SHADOW_BYTES = 2
)(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire reg_req_s   req_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  input wire logic       init_done_lock_i,
  input wire logic       init_complete_i,
  input wire fault_in_s  fault_i,
  input wire logic [7:0] positive_arm_threshold_o,
  input wire logic [7:0] negative_arm_threshold_o,
  input wire logic       pos_compare_en_o,
  input wire logic       neg_compare_en_o,
  input wire logic       arming_enable_o,
  input wire logic [7:0] status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire st_rd = req_i.rd && (req_i.addr == ADDR_STATUS);
  // ---
  // Assertions
  // ---
  rvalid_cause_a: assert property (rvalid_o |-> $past(req_i.rd))
    else $error("read answer without request");
  read_answer_a: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  status_echo_a: assert property (st_rd |=> rdata_o == $past(status_o))
    else $error("status read data wrong");
  thr_locked_a: assert property (init_done_lock_i |=>
      $stable(positive_arm_threshold_o) && $stable(negative_arm_threshold_o))
    else $error("threshold changed while locked");
  pos_enable_a: assert property (1'b1 |=>
      pos_compare_en_o == ($past(positive_arm_threshold_o) != 8'h00))
    else $error("positive compare enable wrong");
  neg_enable_a: assert property (1'b1 |=>
      neg_compare_en_o == ($past(negative_arm_threshold_o) != 8'h00))
    else $error("negative compare enable wrong");
  arm_enable_a: assert property (1'b1 |=>
      arming_enable_o == ($past(positive_arm_threshold_o | negative_arm_threshold_o) != 8'h00))
    else $error("arming enable wrong");
  init_keep_a: assert property (status_o[BIT_INIT] && !init_complete_i |=>
      status_o[BIT_INIT])
    else $error("init flag dropped early");
  reset_with_init_a: assert property (status_o[BIT_INIT] |-> status_o[BIT_RESET])
    else $error("reset flag low during init");
  mod_ovr_clear_a: assert property (st_rd && !fault_i.mod_ovr |=>
      !status_o[BIT_MOD_OVR])
    else $error("over-range flag not cleared");
  miso_set_a: assert property (fault_i.miso |=> status_o[BIT_MISO])
    else $error("mismatch flag not set");
  drift_clear_a: assert property (st_rd && !fault_i.drift |=> !status_o[BIT_DRIFT])
    else $error("drift flag not cleared");
  cover property (st_rd ##1 rdata_o[BIT_MOD_OVR]);
  cover property (init_done_lock_i && req_i.wr);
  cover property ($fell(arming_enable_o));
endmodule // arm_stat_properties

// file: arm_stat_regs.sv
// Arming threshold, status, tick counter and drift correction registers.
// Assumes a one-cycle read or write strobe from serial logic on core_clk_i.
module arm_stat_regs
  import arm_stat_pkg::*;
#(
  parameter int SHADOW_BYTES = 2
)(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire reg_req_s                 req_i,
  output logic [7:0]                    rdata_o,
  output logic                          rvalid_o,
  input  wire logic                     init_done_lock_i,
  input  wire logic                     init_complete_i,
  input  wire logic                     osc_tick_i,
  input  wire fault_in_s                fault_i,
  input  wire logic                     other_fault_i,
  input  wire logic                     fuse_fault_i,
  input  wire logic [7:0]               drift_correction_i,
  input  wire logic [SHADOW_BYTES*8-1:0] shadow_data_i,
  input  wire logic [CRC_WIDTH-1:0]     shadow_crc_i,
  input  wire logic [CRC_WIDTH-1:0]     wr_array_crc_i,
  output logic [7:0]                    positive_arm_threshold_o,
  output logic [7:0]                    negative_arm_threshold_o,
  output logic                          pos_compare_en_o,
  output logic                          neg_compare_en_o,
  output logic                          arming_enable_o,
  output logic [7:0]                    status_o
);

  if (SHADOW_BYTES < 2)
  begin : g_bad_shadow
    $error("arm_stat_regs needs a shadow array of two bytes or more");
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]               pos_thr_ff;
  logic [7:0]               neg_thr_ff;
  logic [PRESCALE_BITS-1:0] pre_ff;
  logic [7:0]               tick_ff;
  logic [7:0]               drift_ff;
  logic                     data_err_ff;
  logic                     mod_ovr_ff;
  logic                     init_ff;
  logic                     miso_ff;
  logic                     drift_flag_ff;
  logic                     res_ff;
  logic                     wr_crc_bad_ff;
  logic                     otp_bad_ff;
  logic                     crc_start_ff;
  logic                     crc_sel_ff;
  logic                     otp_checked_ff;
  logic [7:0]               rdata_ff;
  logic                     rvalid_ff;
  logic                     pos_en_ff;
  logic                     neg_en_ff;
  logic                     arm_en_ff;
  logic [1:0]               tick_sync_ff;
  logic                     tick_old_ff;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wr_ok      = req_i.wr && !init_done_lock_i;
  wire logic wr_pos     = wr_ok && (req_i.addr == ADDR_POS_THR);
  wire logic wr_neg     = wr_ok && (req_i.addr == ADDR_NEG_THR);
  wire logic rd_status  = req_i.rd && (req_i.addr == ADDR_STATUS);
  wire logic tick_edge  = tick_sync_ff[1] && !tick_old_ff;
  wire logic pre_wrap   = tick_edge && (pre_ff == PRESCALE_BITS'(PRESCALE_DIV - 1));

  wire logic [7:0] status_now = {1'b0, data_err_ff, mod_ovr_ff, init_ff, miso_ff,
                                 1'b0, drift_flag_ff, res_ff};

  logic [7:0] rd_mux;
  always_comb
  begin
    case (req_i.addr)
      ADDR_POS_THR: rd_mux = pos_thr_ff;
      ADDR_NEG_THR: rd_mux = neg_thr_ff;
      ADDR_STATUS:  rd_mux = status_now;
      ADDR_TICK:    rd_mux = tick_ff;
      ADDR_DRIFT:   rd_mux = drift_ff;
      ADDR_RSVD_1C: rd_mux = 8'h00;
      ADDR_RSVD_1D: rd_mux = 8'h00;
      default:      rd_mux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // CRC checks: shadow array once, then writable array while locked
  // ----------------------------------------------------------------
  wire logic [SHADOW_BYTES*8-1:0] wr_vec  = (SHADOW_BYTES*8)'({pos_thr_ff, neg_thr_ff});
  wire logic [SHADOW_BYTES*8-1:0] crc_vec = crc_sel_ff ? wr_vec : shadow_data_i;
  wire logic [CRC_WIDTH-1:0]      crc_exp = crc_sel_ff ? wr_array_crc_i : shadow_crc_i;
  logic                           crc_done;
  logic                           crc_mis;

  crc3_serial #(
    .NBYTES     (SHADOW_BYTES)
  ) u_crc (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (crc_start_ff),
    .data_i     (crc_vec),
    .expect_i   (crc_exp),
    .done_o     (crc_done),
    .mismatch_o (crc_mis)
  );

  logic crc_busy_ff;
  wire logic crc_go = !crc_busy_ff && !crc_start_ff &&
                      (!otp_checked_ff || init_done_lock_i);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      crc_start_ff   <= 1'b0;
      crc_busy_ff    <= 1'b0;
      crc_sel_ff     <= 1'b0;
      otp_checked_ff <= 1'b0;
      otp_bad_ff     <= 1'b0;
      wr_crc_bad_ff  <= 1'b0;
    end
    else
    begin
      crc_start_ff <= crc_go;
      if (crc_go)
      begin
        crc_busy_ff <= 1'b1;
        crc_sel_ff  <= otp_checked_ff;
      end
      else if (crc_done)
      begin
        crc_busy_ff <= 1'b0;
        if (!crc_sel_ff)
        begin
          otp_checked_ff <= 1'b1;
          otp_bad_ff     <= crc_mis;
        end
        else if (crc_mis)
          wr_crc_bad_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags: a present fault wins over the clearing read
  // ----------------------------------------------------------------
  wire logic data_err_src = wr_crc_bad_ff || otp_bad_ff || fuse_fault_i || other_fault_i;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      data_err_ff   <= 1'b0;
      mod_ovr_ff    <= 1'b0;
      init_ff       <= 1'b1;
      miso_ff       <= 1'b0;
      drift_flag_ff <= 1'b0;
      res_ff        <= 1'b1;
    end
    else
    begin
      data_err_ff   <= data_err_src || (data_err_ff && !rd_status);
      mod_ovr_ff    <= fault_i.mod_ovr || (mod_ovr_ff && !rd_status);
      miso_ff       <= fault_i.miso || (miso_ff && !rd_status);
      drift_flag_ff <= fault_i.drift || (drift_flag_ff && !rd_status);
      res_ff        <= init_ff || (res_ff && !rd_status);
      if (init_complete_i)
        init_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Thresholds, counter, outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pos_thr_ff   <= RST_THRESHOLD;
      neg_thr_ff   <= RST_THRESHOLD;
      pre_ff       <= '0;
      tick_ff      <= RST_TICK;
      tick_sync_ff <= 2'h0;
      tick_old_ff  <= 1'b0;
      drift_ff     <= 8'h00;
      rdata_ff     <= 8'h00;
      rvalid_ff    <= 1'b0;
      pos_en_ff    <= 1'b0;
      neg_en_ff    <= 1'b0;
      arm_en_ff    <= 1'b0;
    end
    else
    begin
      if (wr_pos)
        pos_thr_ff <= req_i.wdata;
      if (wr_neg)
        neg_thr_ff <= req_i.wdata;
      tick_sync_ff <= {tick_sync_ff[0], osc_tick_i};
      tick_old_ff  <= tick_sync_ff[1];
      if (tick_edge)
        pre_ff <= pre_ff + PRESCALE_BITS'(1);
      if (pre_wrap)
        tick_ff <= tick_ff + 8'h01;
      drift_ff  <= drift_correction_i;
      rvalid_ff <= req_i.rd;
      if (req_i.rd)
        rdata_ff <= rd_mux;
      pos_en_ff <= (pos_thr_ff != 8'h00);
      neg_en_ff <= (neg_thr_ff != 8'h00);
      arm_en_ff <= (pos_thr_ff != 8'h00) || (neg_thr_ff != 8'h00);
    end
  end

  assign rdata_o                  = rdata_ff;
  assign rvalid_o                 = rvalid_ff;
  assign positive_arm_threshold_o = pos_thr_ff;
  assign negative_arm_threshold_o = neg_thr_ff;
  assign pos_compare_en_o         = pos_en_ff;
  assign neg_compare_en_o         = neg_en_ff;
  assign arming_enable_o          = arm_en_ff;
  assign status_o                 = status_now;
endmodule // arm_stat_regs

// file: crc3_serial.sv
// Serial 3-bit CRC engine over a byte stream, one bit per clock.
// Assumes start is pulsed with a stable data vector that holds until done.
module crc3_serial
  import arm_stat_pkg::*;
#(
  parameter int NBYTES = 2
)(
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire logic [NBYTES*8-1:0]   data_i,
  input  wire logic [CRC_WIDTH-1:0]  expect_i,
  output logic                       done_o,
  output logic                       mismatch_o
);
  localparam int NB = NBYTES * 8;
  localparam int IW = $clog2(NB + 1);

  if (NBYTES < 1)
  begin : g_bad_nbytes
    $error("crc3_serial needs at least one byte");
  end

  crc_state_e           st_ff;
  logic [CRC_WIDTH-1:0] crc_ff;
  logic [IW-1:0]        idx_ff;
  logic                 done_ff;
  logic                 mis_ff;

  wire logic                 in_bit   = data_i[NB - 1 - int'(idx_ff)];
  wire logic                 fb       = crc_ff[2] ^ in_bit;
  wire logic [CRC_WIDTH-1:0] nxt_crc  = {crc_ff[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
  wire logic                 last_bit = (idx_ff == IW'(NB - 1));

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_ff   <= CRC_IDLE;
      crc_ff  <= CRC_SEED;
      idx_ff  <= '0;
      done_ff <= 1'b0;
      mis_ff  <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      case (st_ff)
        CRC_IDLE:
        begin
          crc_ff <= CRC_SEED;
          idx_ff <= '0;
          if (start_i)
            st_ff <= CRC_RUN;
        end
        CRC_RUN:
        begin
          crc_ff <= nxt_crc;
          idx_ff <= idx_ff + IW'(1);
          if (last_bit)
            st_ff <= CRC_DONE;
        end
        CRC_DONE:
        begin
          done_ff <= 1'b1;
          mis_ff  <= (crc_ff != expect_i);
          st_ff   <= CRC_IDLE;
        end
        default:
          st_ff <= CRC_IDLE;
      endcase
    end
  end

  assign done_o     = done_ff;
  assign mismatch_o = mis_ff;
endmodule // crc3_serial

// file: reg_master_model.sv
// Register bus master standing in for the serial interface logic.
// Assumes read data arrives exactly one cycle after the read strobe.
module reg_master_model
  import arm_stat_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output reg_req_s        req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    if (a == ADDR_RSVD_1C || a == ADDR_RSVD_1D)
      req_o.wdata = 8'h00;
    @(negedge core_clk_i);
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk_i);
    req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge core_clk_i);
    d = rdata_i;
    v = rvalid_i;
    req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    if (a == ADDR_STATUS)
      d[7] = 1'b0;
  endtask
endmodule // reg_master_model

// file: tb_accel_arming_status_registers.sv
// Self-checking bench of the arming and status register bank.
// Assumes arm_stat_pkg, arm_stat_regs, the checker and the master model.
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb_accel_arming_status_registers
  import arm_stat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, lock = 0, initc = 0, osc = 0, oth = 0, fuse = 0;
  fault_in_s flt = '0;
  logic [7:0] drift = 0, rdata, pthr, nthr, status;
  logic [15:0] sh = 16'h00;
  logic [2:0] shc = 0, wrc = 0;
  logic rvalid, pen, nen, arm;
  reg_req_s req;
  int failures = 0, compares = 0, pos_m = 0, neg_m = 0, p, n;
  int bitpos [4] = '{BIT_DRIFT, BIT_MISO, BIT_MOD_OVR, BIT_DATA_ERR};
  always #2.5 clk = ~clk;
  reg_master_model u_m (.core_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  arm_stat_regs #(.SHADOW_BYTES(2)) u_dut (.core_clk_i(clk), .rst_i(rst), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .init_done_lock_i(lock), .init_complete_i(initc),
    .osc_tick_i(osc), .fault_i(flt), .other_fault_i(oth), .fuse_fault_i(fuse),
    .drift_correction_i(drift), .shadow_data_i(sh), .shadow_crc_i(shc),
    .wr_array_crc_i(wrc), .positive_arm_threshold_o(pthr), .negative_arm_threshold_o(nthr),
    .pos_compare_en_o(pen), .neg_compare_en_o(nen), .arming_enable_o(arm), .status_o(status));
  // ---
  // Model and helpers
  // ---
  function automatic logic [2:0] crc3(input logic [15:0] v);
    logic [2:0] c;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--)
      c = {c[1:0], 1'b0} ^ ((c[2] ^ v[i]) ? CRC_POLY : 3'h0);
    return c;
  endfunction
  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    u_m.wr(a, d);
    if (!lock && a == ADDR_POS_THR) pos_m = d;
    if (!lock && a == ADDR_NEG_THR) neg_m = d;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_m.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ---
  // Tests
  // ---
  initial
  begin
    void'($urandom(48));
    sh = 16'($urandom);
    shc = crc3(sh);
    drift = 8'($urandom);
    repeat (3) @(negedge clk);
    rst = 0;
    rdchk(ADDR_STATUS, 8'h11);
    rdchk(ADDR_STATUS, 8'h11);
    rdchk(ADDR_TICK, RST_TICK);
    rdchk(ADDR_RSVD_1D, 8'h00);
    $display("test reset done");
    p = $urandom_range(255, 1);
    n = $urandom_range(255, 1);
    for (int k = 0; k < 3; k++)
    begin
      wrm(ADDR_POS_THR, 8'(k == 0 ? p : 0));
      wrm(ADDR_NEG_THR, 8'(k == 1 ? n : 0));
      repeat (2) @(negedge clk);
      `CHK("pos_en", pos_m != 0, pen)
      `CHK("neg_en", neg_m != 0, nen)
      `CHK("arm", pos_m + neg_m != 0, arm)
      `CHK("pthr", 8'(pos_m), pthr)
      `CHK("nthr", 8'(neg_m), nthr)
      rdchk(ADDR_POS_THR, 8'(pos_m));
      rdchk(ADDR_NEG_THR, 8'(neg_m));
    end
    $display("test thresholds done");
    initc = 1;
    @(negedge clk) initc = 0;
    rdchk(ADDR_STATUS, 8'h01);
    rdchk(ADDR_STATUS, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      if (i < 3) flt = fault_in_s'(3'(1 << i));
      else oth = 1;
      rdchk(ADDR_STATUS, 8'(1 << bitpos[i]));
      flt = '0;
      oth = 0;
      rdchk(ADDR_STATUS, 8'(1 << bitpos[i]));
      rdchk(ADDR_STATUS, 8'h00);
    end
    $display("test flags done");
    drift = 8'($urandom);
    rdchk(ADDR_DRIFT, drift);
    for (int t = 0; t < PRESCALE_DIV * 4; t++)
      @(negedge clk) osc = t[1] ^ t[0];
    repeat (8) @(negedge clk);
    rdchk(ADDR_TICK, 8'h01);
    $display("test counter done");
    wrm(ADDR_POS_THR, 8'(p));
    wrc = crc3({8'(pos_m), 8'(neg_m)});
    lock = 1;
    wrm(ADDR_POS_THR, 8'(~p));
    wrm(ADDR_RSVD_1C, 8'h5a);
    rdchk(ADDR_POS_THR, 8'(pos_m));
    rdchk(ADDR_RSVD_1C, 8'h00);
    repeat (40) @(negedge clk);
    rdchk(ADDR_STATUS, 8'h00);
    wrc = ~wrc;
    repeat (40) @(negedge clk);
    rdchk(ADDR_STATUS, 8'h40);
    rdchk(ADDR_STATUS, 8'h40);
    `CHK("status", 8'h40, status)
    $display("test lock done");
    for (int j = 0; j < 2; j++)
    begin
      lock = 0;
      shc = j == 0 ? ~crc3(sh) : crc3(sh);
      fuse = j == 1;
      rst = 1;
      repeat (3) @(negedge clk);
      rst = 0;
      repeat (40) @(negedge clk);
      rdchk(ADDR_STATUS, 8'h51);
    end
    $display("test integrity done");
    results();
  end
  initial
  begin
    #200000;
    failures++;
    results();
  end
endmodule // tb_accel_arming_status_registers
bind arm_stat_regs arm_stat_properties #(.SHADOW_BYTES(SHADOW_BYTES)) u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .init_done_lock_i(init_done_lock_i),
  .init_complete_i(init_complete_i), .fault_i(fault_i),
  .positive_arm_threshold_o(positive_arm_threshold_o),
  .negative_arm_threshold_o(negative_arm_threshold_o),
  .pos_compare_en_o(pos_compare_en_o), .neg_compare_en_o(neg_compare_en_o),
  .arming_enable_o(arming_enable_o), .status_o(status_o));
